// >>> pkg/uss_map.svh
// Functional notes
// - Sleep entered only from normal on suspend
// - Resume or enabled wake returns to normal
// - Unconfigured sleeps only in level two
// - Select codes 00,01,10,11; default 10
// - Deconfigure returns select field to 10
// - Select ignored in U1, U2, L1
// - USB or pin reset gives unconfigured normal
// - Level zero wakes on five sources
// - Level zero stops PLLs, oscillator runs
// - LAN wake starts PLL, output clocks
// - Level one behaves as level zero
// - Level two wakes on GPIO only
// - Level three powers down front ends only
// - Level three exits on energy wake terms
// - Level three stores wake and later frames
// - Filter wake frame wakes and is stored
// - Detach enable drops bus and PLLs
// - Link or GPIO restores PLL, ends, attach
// - Detach flag tells reload cause
// - Ready only once PHY operational
`ifndef USS_MAP_SVH
`define USS_MAP_SVH
`define USS_SEL_S0       2'h0
`define USS_SEL_S1       2'h1
`define USS_SEL_S2       2'h2
`define USS_SEL_S3       2'h3
`define USS_SEL_RST      2'h2
`define USS_ADDR_PWR     4'h0
`define USS_ADDR_WAKE    4'h4
`define USS_ADDR_HWCFG   4'h8
`define USS_ADDR_STAT    4'hC
`define USS_AW           4
`define USS_RESP_OKAY    2'h0
`define USS_RESP_SLVERR  2'h2
// Power control fields
`define USS_F_SEL_LO     0
`define USS_F_SEL_HI     1
`define USS_F_RXW_EN     4
`define USS_F_TXW_EN     5
`define USS_F_FILT_EN    6
`define USS_F_LAN_EN     7
`define USS_F_PHY_EN     8
`define USS_F_EEE_EN     9
// Wake enable fields
`define USS_F_GPIO_EN    0
// Hardware config fields
`define USS_F_DET_EN     0
`define USS_F_DET_FLAG   1
`endif

// >>> pkg/uss_pkg.sv
package uss_pkg;
   typedef enum logic [2:0] {
      USS_NORM_UNCFG, USS_NORM_CFG, USS_SLEEP, USS_DETACH, USS_REATTACH
   } uss_state_t;

   // Wake sources seen at the device edge
   typedef struct packed {
      logic gpio;
      logic lan;
      logic magic;
      logic link_chg;
      logic eee;
      logic energy_rx;
      logic good_frame;
   } uss_wake_t;

   // Power controls driven out to the analog and clock blocks
   typedef struct packed {
      logic pll_on;
      logic out_clk_on;
      logic afe_usb2_on;
      logic afe_ss_on;
      logic attached;
      logic fifo_store;
      logic phy_reset;
   } uss_pwr_t;
endpackage

// >>> logic/uss_axil.sv
`timescale 1ns/1ps
`default_nettype none
`include "uss_map.svh"
// Single-outstanding AXI4-Lite slave; presents one write and one read strobe
module uss_axil
   import uss_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic [3:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [3:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic             wr_stb,
   output logic [3:0]       wr_addr,
   output logic [31:0]      wr_data,
   output logic             rd_stb,
   output logic [3:0]       rd_addr,
   input  wire logic [31:0] rd_data,
   input  wire logic        rd_err,
   input  wire logic        wr_err
);
   logic       aw_hold_q;
   logic       w_hold_q;
   logic [3:0] aw_q;
   logic [31:0] wd_q;
   wire aw_take = awvalid && awready;
   wire w_take  = wvalid && wready;
   wire both    = (aw_hold_q || aw_take) && (w_hold_q || w_take);
   wire go_wr   = both && !bvalid;
   wire go_rd   = arvalid && arready;

   assign awready = !aw_hold_q && !bvalid;
   assign wready  = !w_hold_q && !bvalid;
   assign arready = !rvalid;
   assign wr_stb  = go_wr;
   assign wr_addr = aw_take ? awaddr : aw_q;
   // Partial strobes write whole word; registers are control bits only
   assign wr_data = w_take ? wdata : wd_q;
   assign rd_stb  = go_rd;
   assign rd_addr = araddr;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         aw_q      <= 4'h0;
         wd_q      <= 32'h0;
         bvalid    <= 1'b0;
         bresp     <= 2'h0;
         rvalid    <= 1'b0;
         rresp     <= 2'h0;
         rdata     <= 32'h0;
      end else begin
         if (aw_take) aw_q <= awaddr;
         if (w_take) wd_q <= wdata;
         aw_hold_q <= go_wr ? 1'b0 : (aw_hold_q || aw_take);
         w_hold_q  <= go_wr ? 1'b0 : (w_hold_q || w_take);
         if (go_wr) begin
            bvalid <= 1'b1;
            bresp  <= wr_err ? `USS_RESP_SLVERR : `USS_RESP_OKAY;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
         if (go_rd) begin
            rvalid <= 1'b1;
            rdata  <= rd_data;
            rresp  <= rd_err ? `USS_RESP_SLVERR : `USS_RESP_OKAY;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end
   wire unused_ok = &{1'b0, wstrb};
endmodule
`default_nettype wire

// >>> logic/uss_ctrl.sv
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "uss_map.svh"
module uss_ctrl
   import uss_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               nrst,
   input  wire logic [3:0]         s_awaddr,
   input  wire logic               s_awvalid,
   output logic                    s_awready,
   input  wire logic [31:0]        s_wdata,
   input  wire logic [3:0]         s_wstrb,
   input  wire logic               s_wvalid,
   output logic                    s_wready,
   output logic [1:0]              s_bresp,
   output logic                    s_bvalid,
   input  wire logic               s_bready,
   input  wire logic [3:0]         s_araddr,
   input  wire logic               s_arvalid,
   output logic                    s_arready,
   output logic [31:0]             s_rdata,
   output logic [1:0]              s_rresp,
   output logic                    s_rvalid,
   input  wire logic               s_rready,
   input  wire logic               usb_suspend,
   input  wire logic               usb_u3,
   input  wire logic               usb_resume,
   input  wire logic               usb_reset,
   input  wire logic               hard_reset,
   input  wire logic               set_config,
   input  wire logic               clr_config,
   input  wire logic               phy_ready,
   input  wire logic               link_up,
   input  wire uss_pkg::uss_wake_t wake_in,
   output uss_pkg::uss_pwr_t       pwr_out,
   output logic                    ready,
   output logic                    remote_wake,
   output logic [2:0]              state_out
);
   import uss_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave
   logic        wr_stb;
   logic [3:0]  wr_addr;
   logic [31:0] wr_data;
   logic        rd_stb;
   logic [3:0]  rd_addr;
   logic [31:0] rd_data;
   wire         rd_err;
   wire         wr_err;

   uss_axil u_bus (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .awaddr  (s_awaddr),
      .awvalid (s_awvalid),
      .awready (s_awready),
      .wdata   (s_wdata),
      .wstrb   (s_wstrb),
      .wvalid  (s_wvalid),
      .wready  (s_wready),
      .bresp   (s_bresp),
      .bvalid  (s_bvalid),
      .bready  (s_bready),
      .araddr  (s_araddr),
      .arvalid (s_arvalid),
      .arready (s_arready),
      .rdata   (s_rdata),
      .rresp   (s_rresp),
      .rvalid  (s_rvalid),
      .rready  (s_rready),
      .wr_stb  (wr_stb),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .rd_stb  (rd_stb),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_err  (rd_err),
      .wr_err  (wr_err)
   );

   ////////////////////////////////////////////////////////////////////////
   // Registers
   uss_state_t  st_q;
   uss_state_t  st_d;
   logic        cfg_q;
   logic [1:0]  sel_q;
   logic [1:0]  lvl_q;
   logic        rxw_en_q;
   logic        txw_en_q;
   logic        filt_en_q;
   logic        lan_en_q;
   logic        phy_en_q;
   logic        eee_en_q;
   logic        gpio_en_q;
   logic        det_en_q;
   logic        det_flag_q;
   logic        wake_q;
   logic        susp_q;

   wire sel_pwr   = (wr_addr == `USS_ADDR_PWR);
   wire sel_wake  = (wr_addr == `USS_ADDR_WAKE);
   wire sel_hw    = (wr_addr == `USS_ADDR_HWCFG);
   wire wr_pwr    = wr_stb && sel_pwr;
   wire wr_wake   = wr_stb && sel_wake;
   wire wr_hw     = wr_stb && sel_hw;
   assign wr_err  = !(sel_pwr || sel_wake || sel_hw);
   assign rd_err  = !(rd_addr == `USS_ADDR_PWR || rd_addr == `USS_ADDR_WAKE
                   || rd_addr == `USS_ADDR_HWCFG || rd_addr == `USS_ADDR_STAT);

   wire [31:0] pwr_word = {22'h0, eee_en_q, phy_en_q, lan_en_q, filt_en_q,
                           txw_en_q, rxw_en_q, 2'h0, sel_q};
   wire [31:0] hw_word  = {30'h0, det_flag_q, det_en_q};
   wire [31:0] st_word  = {25'h0, ready, cfg_q, lvl_q, st_q};
   assign rd_data = (rd_addr == `USS_ADDR_PWR)   ? pwr_word :
                    (rd_addr == `USS_ADDR_WAKE)  ? {31'h0, gpio_en_q} :
                    (rd_addr == `USS_ADDR_HWCFG) ? hw_word :
                    (rd_addr == `USS_ADDR_STAT)  ? st_word : 32'h0;

   ////////////////////////////////////////////////////////////////////////
   // Sleep entry and wake decode
   // Suspend is a level; entry only on its rising edge keeps a held
   // suspend from re-entering sleep right after a wake
   wire susp_lvl  = usb_suspend || usb_u3;
   wire susp_rise = susp_lvl && !susp_q;
   wire in_norm   = (st_q == USS_NORM_UNCFG) || (st_q == USS_NORM_CFG);
   wire any_rst   = usb_reset || hard_reset;
   // Unconfigured forces level two
   wire [1:0] ent_lvl = cfg_q ? sel_q : `USS_SEL_S2;

   wire lvl01 = (lvl_q == `USS_SEL_S0) || (lvl_q == `USS_SEL_S1);
   wire w01 = (gpio_en_q && wake_in.gpio)
           || (lan_en_q && (wake_in.lan || wake_in.magic))
           || (phy_en_q && wake_in.link_chg)
           || (eee_en_q && wake_in.eee);
   wire w2  = gpio_en_q && wake_in.gpio;
   wire w3  = (gpio_en_q && wake_in.gpio)
           || (lan_en_q && (wake_in.lan || wake_in.magic))
           || (phy_en_q && wake_in.link_chg)
           || (rxw_en_q && wake_in.energy_rx) || txw_en_q
           || (filt_en_q && wake_in.good_frame);
   wire wake_hit = lvl01 ? w01 :
                   (lvl_q == `USS_SEL_S2) ? w2 : w3;
   wire det_wake = link_up || (gpio_en_q && wake_in.gpio);

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         USS_NORM_UNCFG,
         USS_NORM_CFG: begin
            if (det_en_q)
               st_d = USS_DETACH;
            else if (susp_rise)
               st_d = USS_SLEEP;
            else if (set_config)
               st_d = USS_NORM_CFG;
            else if (clr_config)
               st_d = USS_NORM_UNCFG;
         end
         USS_SLEEP: begin
            if (usb_resume || wake_hit)
               st_d = cfg_q ? USS_NORM_CFG : USS_NORM_UNCFG;
         end
         USS_DETACH: begin
            if (det_wake)
               st_d = USS_REATTACH;
         end
         USS_REATTACH: st_d = USS_NORM_UNCFG;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State and control registers
   always_ff @(posedge sys_clk) begin
      if (!nrst || any_rst) begin
         st_q   <= USS_NORM_UNCFG;
         cfg_q  <= 1'b0;
         sel_q  <= `USS_SEL_RST;
         lvl_q  <= `USS_SEL_RST;
         susp_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         susp_q <= susp_lvl;
         wake_q <= (st_q == USS_SLEEP) && (st_d != USS_SLEEP) && !usb_resume;
         if (in_norm && st_d == USS_SLEEP)
            lvl_q <= ent_lvl;
         if (st_d == USS_NORM_CFG)
            cfg_q <= 1'b1;
         else if (st_d == USS_NORM_UNCFG)
            cfg_q <= 1'b0;
         if (in_norm && clr_config)
            sel_q <= `USS_SEL_RST;
         else if (wr_pwr)
            sel_q <= wr_data[`USS_F_SEL_HI:`USS_F_SEL_LO];
      end
   end

   // Enables do not survive a USB reset; nrst, pin reset and bus reset all clear them
   always_ff @(posedge sys_clk) begin
      if (!nrst || any_rst) begin
         rxw_en_q  <= 1'b0;
         txw_en_q  <= 1'b0;
         filt_en_q <= 1'b0;
         lan_en_q  <= 1'b0;
         phy_en_q  <= 1'b0;
         eee_en_q  <= 1'b0;
         gpio_en_q <= 1'b0;
         det_en_q  <= 1'b0;
      end else begin
         if (wr_pwr) begin
            rxw_en_q  <= wr_data[`USS_F_RXW_EN];
            txw_en_q  <= wr_data[`USS_F_TXW_EN];
            filt_en_q <= wr_data[`USS_F_FILT_EN];
            lan_en_q  <= wr_data[`USS_F_LAN_EN];
            phy_en_q  <= wr_data[`USS_F_PHY_EN];
            eee_en_q  <= wr_data[`USS_F_EEE_EN];
         end
         if (wr_wake)
            gpio_en_q <= wr_data[`USS_F_GPIO_EN];
         // Enable self-clears once detached so a reload starts clean
         if (st_q == USS_DETACH)
            det_en_q <= 1'b0;
         else if (wr_hw)
            det_en_q <= wr_data[`USS_F_DET_EN];
      end
   end

   // Flag survives USB reset so the reloaded driver can read it
   always_ff @(posedge sys_clk) begin
      if (!nrst || hard_reset) begin
         det_flag_q <= 1'b0;
      end else if (st_q == USS_REATTACH) begin
         det_flag_q <= 1'b1;
      end else if (wr_hw && wr_data[`USS_F_DET_FLAG]) begin
         det_flag_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Power outputs
   wire sleeping = (st_d == USS_SLEEP);
   wire lvl_nx   = (in_norm && st_d == USS_SLEEP) ? 1'b1 : 1'b0;
   wire [1:0] lv = lvl_nx ? ent_lvl : lvl_q;
   wire lv3      = (lv == `USS_SEL_S3);
   wire detached = (st_d == USS_DETACH);
   uss_pwr_t pwr_d;

   always_comb begin
      pwr_d             = '0;
      // Level three keeps clocks; zero, one and two stop the PLLs
      pwr_d.pll_on      = !detached && (!sleeping || lv3);
      pwr_d.out_clk_on  = !detached && (!sleeping || lv3);
      pwr_d.afe_usb2_on = !detached && !sleeping;
      pwr_d.afe_ss_on   = !detached && !sleeping;
      pwr_d.attached    = !detached;
      pwr_d.fifo_store  = sleeping && lv3;
      pwr_d.phy_reset   = (st_d == USS_NORM_UNCFG)
                       || (sleeping && !cfg_q);
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst || any_rst) begin
         pwr_out     <= '0;
         ready       <= 1'b0;
         remote_wake <= 1'b0;
         state_out   <= 3'h0;
      end else begin
         pwr_out     <= pwr_d;
         ready       <= (st_d == USS_NORM_CFG) && phy_ready;
         remote_wake <= wake_q;
         state_out   <= st_d;
      end
   end
endmodule
`default_nettype wire

// >>> testbench/uss_properties.sv
`timescale 1ns/1ps
`default_nettype none
module uss_props (
   input wire logic             sys_clk,
   input wire logic             nrst,
   input wire logic             usb_suspend,
   input wire logic             usb_u3,
   input wire logic             usb_resume,
   input wire logic             usb_reset,
   input wire logic             hard_reset,
   input wire logic             phy_ready,
   input wire uss_pkg::uss_pwr_t pwr_out,
   input wire logic             ready,
   input wire logic             remote_wake,
   input wire logic [2:0]       state_out
);
   import uss_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire rst_any = usb_reset | hard_reset;
   ////////////////////////////////////////////////////////////////////////
   AST_ENTER:
      assert property ($rose(usb_suspend | usb_u3) && state_out <= 3'h1 &&
         !rst_any && !usb_resume |=> state_out == 3'h2)
         else $error("sleep not entered on suspend");
   AST_FROM_NORMAL:
      assert property ($changed(state_out) && state_out == 3'h2
         |-> $past(state_out) <= 3'h1)
         else $error("sleep entered from a non-normal state");
   AST_RESUME:
      assert property (state_out == 3'h2 && usb_resume && !rst_any
         |=> state_out <= 3'h1)
         else $error("resume did not return to normal");
   AST_RESET:
      assert property (rst_any |=> state_out == 3'h0 && !ready)
         else $error("reset did not give unconfigured normal");
   AST_READY:
      assert property (!phy_ready |=> !ready)
         else $error("ready without operational phy");
   AST_DETACH:
      assert property (state_out == 3'h3
         |-> !pwr_out.pll_on && !pwr_out.attached)
         else $error("detach left pll or bus on");
   AST_REATTACH:
      assert property (state_out == 3'h4 |-> pwr_out.pll_on &&
         pwr_out.afe_usb2_on && pwr_out.afe_ss_on)
         else $error("reattach without pll and front ends");
   AST_WAKE_PULSE:
      assert property ($rose(remote_wake)
         |-> $past(state_out, 2) == 3'h2 && state_out <= 3'h1)
         else $error("remote wake not tied to a sleep exit");
endmodule

bind uss_ctrl uss_props u_props (.sys_clk, .nrst, .usb_suspend, .usb_u3,
   .usb_resume, .usb_reset, .hard_reset, .phy_ready, .pwr_out, .ready,
   .remote_wake, .state_out);
`default_nettype wire

// >>> testbench/uss_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host side: link suspend, resume, bus reset and configuration requests
module uss_host (
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic [2:0] cmd,
   input  wire logic       remote_wake,
   output logic            usb_suspend,
   output logic            usb_u3,
   output logic            usb_resume,
   output logic            usb_reset,
   output logic            set_config,
   output logic            clr_config
);
   always_ff @(posedge sys_clk) begin
      usb_resume <= 1'b0;
      usb_reset  <= 1'b0;
      set_config <= 1'b0;
      clr_config <= 1'b0;
      // Link leaves suspend once the device signals a wake
      if (!nrst || remote_wake || cmd == 3'h3 || cmd == 3'h4) begin
         usb_suspend <= 1'b0;
         usb_u3      <= 1'b0;
      end
      if (nrst) begin
         case (cmd)
            3'h1: usb_suspend <= 1'b1;
            3'h2: usb_u3 <= 1'b1;
            3'h3: usb_resume <= 1'b1;
            3'h4: usb_reset <= 1'b1;
            3'h5: set_config <= 1'b1;
            3'h6: clr_config <= 1'b1;
            default: ;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> testbench/uss_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uss_ctrl_tb;
   import uss_pkg::*;
   logic        sys_clk, nrst, hard_reset, phy_ready, link_up, seen;
   logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid;
   logic        s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
   logic        usb_suspend, usb_u3, usb_resume, usb_reset, ready;
   logic        set_config, clr_config, remote_wake;
   logic [3:0]  s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, rdv;
   logic [1:0]  s_bresp, s_rresp, rsp;
   logic [2:0]  state_out, cmd;
   uss_wake_t   wake_in;
   uss_pwr_t    pwr_out;
   int          miscompares, checks_done;

   uss_ctrl dut (.sys_clk, .nrst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
      .s_wstrb(4'hF), .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
      .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
      .s_rready, .usb_suspend, .usb_u3, .usb_resume, .usb_reset, .hard_reset,
      .set_config, .clr_config, .phy_ready, .link_up, .wake_in, .pwr_out,
      .ready, .remote_wake, .state_out);
   uss_host host (.sys_clk, .nrst, .cmd, .remote_wake, .usb_suspend, .usb_u3,
      .usb_resume, .usb_reset, .set_config, .clr_config);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic report_and_stop();
      if (miscompares == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      bit done;
      @(posedge sys_clk);
      s_awaddr  <= a;
      s_wdata   <= d;
      s_awvalid <= 1'b1;
      s_wvalid  <= 1'b1;
      s_bready  <= 1'b1;
      done = 0;
      while (!done) begin
         @(posedge sys_clk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
         if (s_bvalid) begin
            rsp = s_bresp;
            s_bready <= 1'b0;
            done = 1;
         end
      end
   endtask

   task automatic axr(input logic [3:0] a);
      bit done;
      @(posedge sys_clk);
      s_araddr  <= a;
      s_arvalid <= 1'b1;
      s_rready  <= 1'b1;
      done = 0;
      while (!done) begin
         @(posedge sys_clk);
         if (s_arready) s_arvalid <= 1'b0;
         if (s_rvalid) begin
            rdv = s_rdata;
            rsp = s_rresp;
            s_rready <= 1'b0;
            done = 1;
         end
      end
   endtask

   task automatic rdc(input string nm, input logic [3:0] a,
                      input logic [31:0] m, e);
      axr(a);
      chk(nm, rdv & m, e);
   endtask

   task automatic hc(input logic [2:0] c);
      @(posedge sys_clk);
      cmd <= c;
      @(posedge sys_clk);
      cmd <= 3'h0;
   endtask

   // Bounded wait, one spare edge so power outputs settle too
   task automatic wst(input logic [2:0] e);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (state_out !== e && n < 30);
      @(posedge sys_clk);
      chk("state", 32'(state_out), 32'(e));
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdc("select", 4'h0, 32'h3, 32'h2);
      chk("phy_reset", 32'(pwr_out.phy_reset), 32'h1);
      axr(4'h2);
      chk("unmapped", 32'(rsp), 32'h2);
   endtask

   task automatic t_uncfg();
      axw(4'h0, 32'h83);
      axw(4'h4, 32'h1);
      hc(3'h2);
      wst(3'h2);
      rdc("level", 4'hC, 32'h18, 32'h10);
      wake_in.lan <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk("lan_ignored", 32'(state_out), 32'h2);
      wake_in.lan  <= 1'b0;
      wake_in.gpio <= 1'b1;
      wst(3'h0);
      wake_in.gpio <= 1'b0;
   endtask

   task automatic t_lvl0(input logic [1:0] sel);
      hc(3'h5);
      axw(4'h0, {30'h20, sel});
      hc(3'h1);
      wst(3'h2);
      chk("pll_off", 32'(pwr_out.pll_on), 32'h0);
      wake_in.lan <= 1'b1;
      wst(3'h1);
      chk("pll_on", 32'(pwr_out.pll_on), 32'h1);
      chk("clk_on", 32'(pwr_out.out_clk_on), 32'h1);
      wake_in.lan <= 1'b0;
   endtask

   task automatic t_lvl3();
      axw(4'h0, 32'h43);
      hc(3'h1);
      wst(3'h2);
      chk("afe", 32'(pwr_out.afe_usb2_on), 32'h0);
      chk("pll3", 32'(pwr_out.pll_on), 32'h1);
      chk("store", 32'(pwr_out.fifo_store), 32'h1);
      wake_in.good_frame <= 1'b1;
      wst(3'h1);
      wake_in.good_frame <= 1'b0;
   endtask

   task automatic t_energy();
      axw(4'h0, 32'h13);
      hc(3'h1);
      wst(3'h2);
      wake_in.energy_rx <= 1'b1;
      wst(3'h1);
      wake_in.energy_rx <= 1'b0;
      axw(4'h0, 32'h23);
      hc(3'h1);
      seen = 1'b0;
      repeat (20) begin
         @(posedge sys_clk);
         if (remote_wake) seen = 1'b1;
      end
      chk("tx_wake", 32'(seen), 32'h1);
   endtask

   task automatic t_resume();
      axw(4'h0, 32'h2);
      hc(3'h1);
      wst(3'h2);
      phy_ready <= 1'b0;
      hc(3'h3);
      wst(3'h1);
      chk("ready_lo", 32'(ready), 32'h0);
      phy_ready <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk("ready_hi", 32'(ready), 32'h1);
      axw(4'h0, 32'h0);
      hc(3'h6);
      rdc("sel_deconf", 4'h0, 32'h3, 32'h2);
   endtask

   task automatic t_rst();
      hc(3'h1);
      wst(3'h2);
      hard_reset <= 1'b1;
      @(posedge sys_clk);
      hard_reset <= 1'b0;
      @(posedge sys_clk);
      chk("hard_rst", 32'(state_out), 32'h0);
      // Bus still suspended, so the device sleeps again; resume it
      hc(3'h3);
      wst(3'h0);
      hc(3'h5);
      hc(3'h1);
      wst(3'h2);
      hc(3'h4);
      wst(3'h0);
   endtask

   task automatic t_detach();
      hc(3'h5);
      axw(4'h8, 32'h1);
      phy_ready <= 1'b0;
      wst(3'h3);
      chk("attached", 32'(pwr_out.attached), 32'h0);
      link_up <= 1'b1;
      wst(3'h0);
      chk("ss_afe", 32'(pwr_out.afe_ss_on), 32'h1);
      chk("ready_det", 32'(ready), 32'h0);
      phy_ready <= 1'b1;
      rdc("det_flag", 4'h8, 32'h2, 32'h2);
      axw(4'h8, 32'h2);
      rdc("det_clr", 4'h8, 32'h2, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      report_and_stop();
   end

   initial begin
      nrst <= 1'b0;
      hard_reset <= 1'b0;
      phy_ready <= 1'b1;
      link_up <= 1'b0;
      wake_in <= '0;
      cmd <= 3'h0;
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= 5'h0;
      s_awaddr <= 4'h0;
      s_araddr <= 4'h0;
      s_wdata <= 32'h0;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      t_reset();
      t_uncfg();
      for (int i = 0; i < 2; i++) t_lvl0(i[1:0]);
      t_lvl3();
      t_energy();
      t_resume();
      t_rst();
      t_detach();
      report_and_stop();
   end
endmodule
`default_nettype wire
